// ===== bkdr_defines.svh
`ifndef BKDR_DEFINES_SVH
`define BKDR_DEFINES_SVH

// register offsets, at the printed addresses
`define BKDR_ADDR_W          10
`define BKDR_OFS_INPUT_DUTY  10'h2a6
`define BKDR_OFS_OUTPUT_DUTY 10'h2a8
`define BKDR_OFS_SINK_DAC    10'h2aa
`define BKDR_OFS_BOOST_CODE  10'h2ac
`define BKDR_OFS_DETECTION   10'h2ae

// register indices inside the bank
`define BKDR_NUM_REGS        5
`define BKDR_IDX_W           3
`define BKDR_IDX_INPUT_DUTY  3'h0
`define BKDR_IDX_OUTPUT_DUTY 3'h1
`define BKDR_IDX_SINK_DAC    3'h2
`define BKDR_IDX_BOOST_CODE  3'h3
`define BKDR_IDX_DETECTION   3'h4

// word layout
`define BKDR_DATA_W          16
`define BKDR_RST_WORD        16'h0000
`define BKDR_DAC_W           12
`define BKDR_BOOST_W         11
`define BKDR_DIM_MSB         8
`define BKDR_DIM_LSB         6
`define BKDR_SW_MSB          5
`define BKDR_SW_LSB          3
`define BKDR_GRP_MSB         2
`define BKDR_GRP_LSB         0

// boost code scale: vout = ref * ratio + r_upper * step * code
`define BKDR_BOOST_REF_MV    1200
`define BKDR_BOOST_STEP_FA   18750000

`endif

// ===== bkdr_pkg.sv
package bkdr_pkg;

	typedef enum logic [2:0] {
		bkdr_dim_152hz,
		bkdr_dim_305hz,
		bkdr_dim_610hz,
		bkdr_dim_1k22hz,
		bkdr_dim_2k44hz,
		bkdr_dim_4k88hz,
		bkdr_dim_9k77hz,
		bkdr_dim_19k53hz
	} bkdr_dim_freq_type;

	typedef enum logic [2:0] {
		bkdr_sw_303khz,
		bkdr_sw_400khz,
		bkdr_sw_606khz,
		bkdr_sw_800khz,
		bkdr_sw_1mhz,
		bkdr_sw_1m25hz,
		bkdr_sw_1m67hz,
		bkdr_sw_2m2hz
	} bkdr_sw_freq_type;

	typedef enum logic [2:0] {
		bkdr_grp_six_single,
		bkdr_grp_five_single,
		bkdr_grp_four_single,
		bkdr_grp_three_single,
		bkdr_grp_two_single,
		bkdr_grp_pairs_three,
		bkdr_grp_triples_two,
		bkdr_grp_all_one
	} bkdr_grouping_type;

	// values from the brightness path, boost loop and detection, each with a load pulse
	typedef struct packed {
		logic [15:0]       input_duty;
		logic              input_duty_load;
		logic [15:0]       applied_duty_code;
		logic              duty_load;
		logic [11:0]       applied_sink_dac_code;
		logic              dac_load;
		logic [10:0]       adaptive_boost_code;
		logic              boost_load;
		bkdr_dim_freq_type detected_dimming_frequency;
		bkdr_sw_freq_type  detected_switching_frequency;
		bkdr_grouping_type detected_string_grouping;
		logic              detect_done;
	} bkdr_src_type;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [9:0]  addr;
		logic [15:0] wdata;
	} bkdr_req_type;

	typedef struct packed {
		logic        ack;
		logic        addr_err;
		logic [15:0] rdata;
	} bkdr_rsp_type;

endpackage

// ===== bkdr_snapshot.sv
`timescale 1ns/1ps
`include "bkdr_defines.svh"

module bkdr_snapshot
	import bkdr_pkg::*;
#(
	parameter int WIDTH = `BKDR_DATA_W
) (
	input  wire logic             core_clk,
	input  wire logic             reset_n,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] value,
	output logic      [WIDTH-1:0] held
);

	typedef struct packed {
		logic [WIDTH-1:0] held;
	} bkdr_snap_state_type;

	bkdr_snap_state_type state_r;
	bkdr_snap_state_type state_nxt;

	generate
		if (WIDTH < 1 || WIDTH > `BKDR_DATA_W) begin : g_bad_width
			$error("snapshot width must be 1 to 16");
		end
	endgenerate

	// whole word taken on one edge, so a reader never sees a half-updated value
	always_comb begin
		state_nxt = state_r;
		if (load) begin
			state_nxt.held = value;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			state_r <= '{held: '0};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign held = state_r.held;

endmodule

// ===== bkdr_readback.sv
`timescale 1ns/1ps
`include "bkdr_defines.svh"


module bkdr_readback
	import bkdr_pkg::*;
(
	input  wire logic         core_clk,
	input  wire logic         reset_n,
	input  wire bkdr_src_type src,
	input  wire bkdr_req_type req,
	output bkdr_rsp_type      rsp_r,
	output logic              detect_seen_r
);

	typedef struct packed {
		bkdr_rsp_type rsp;
		logic         detect_seen;
	} bkdr_state_type;

	bkdr_state_type state_r;
	bkdr_state_type state_nxt;

	logic [`BKDR_DATA_W-1:0] src_word  [`BKDR_NUM_REGS];
	logic                    src_load  [`BKDR_NUM_REGS];
	logic [`BKDR_DATA_W-1:0] held_word [`BKDR_NUM_REGS];
	logic [`BKDR_DATA_W-1:0] det_word;
	logic [`BKDR_IDX_W-1:0]  rd_index;
	logic                    rd_hit;

	// word layout must fit the bank, or one field would alias another on a read
	generate
		if (`BKDR_DAC_W > `BKDR_DATA_W) begin : g_bad_dac_w
			$error("dac field wider than the readback word");
		end
		if (`BKDR_BOOST_W > `BKDR_DATA_W) begin : g_bad_boost_w
			$error("boost field wider than the readback word");
		end
		if (`BKDR_DIM_MSB >= `BKDR_DATA_W) begin : g_bad_dim_top
			$error("dimming field above the readback word");
		end
		if (`BKDR_DIM_MSB < `BKDR_DIM_LSB) begin : g_bad_dim_order
			$error("dimming field bounds reversed");
		end
		if (`BKDR_SW_MSB < `BKDR_SW_LSB) begin : g_bad_sw_order
			$error("switching field bounds reversed");
		end
		if (`BKDR_GRP_MSB < `BKDR_GRP_LSB) begin : g_bad_grp_order
			$error("grouping field bounds reversed");
		end
		if (`BKDR_DIM_LSB <= `BKDR_SW_MSB) begin : g_dim_sw_overlap
			$error("dimming and switching fields overlap");
		end
		if (`BKDR_SW_LSB <= `BKDR_GRP_MSB) begin : g_sw_grp_overlap
			$error("switching and grouping fields overlap");
		end

		// field widths must match the code types carried in from detection
		if (`BKDR_DIM_MSB - `BKDR_DIM_LSB + 1 != $bits(bkdr_dim_freq_type)) begin : g_dim_w
			$error("dimming field width differs from its code");
		end
		if (`BKDR_SW_MSB - `BKDR_SW_LSB + 1 != $bits(bkdr_sw_freq_type)) begin : g_sw_w
			$error("switching field width differs from its code");
		end
		if (`BKDR_GRP_MSB - `BKDR_GRP_LSB + 1 != $bits(bkdr_grouping_type)) begin : g_grp_w
			$error("grouping field width differs from its code");
		end
		if ($bits(`BKDR_RST_WORD) != `BKDR_DATA_W) begin : g_rst_w
			$error("reset word width differs from the readback word");
		end

		// index must reach every word of the bank
		if (`BKDR_NUM_REGS > (2 ** `BKDR_IDX_W)) begin : g_idx_narrow
			$error("register index too narrow for the bank");
		end
		if (`BKDR_IDX_DETECTION >= `BKDR_NUM_REGS) begin : g_idx_range
			$error("detection index outside the bank");
		end

		// offsets strictly ascending, so no two words share an address
		if (`BKDR_OFS_OUTPUT_DUTY <= `BKDR_OFS_INPUT_DUTY) begin : g_ofs_order_0
			$error("output duty offset not above input duty offset");
		end
		if (`BKDR_OFS_SINK_DAC <= `BKDR_OFS_OUTPUT_DUTY) begin : g_ofs_order_1
			$error("sink dac offset not above output duty offset");
		end
		if (`BKDR_OFS_BOOST_CODE <= `BKDR_OFS_SINK_DAC) begin : g_ofs_order_2
			$error("boost offset not above sink dac offset");
		end
		if (`BKDR_OFS_DETECTION <= `BKDR_OFS_BOOST_CODE) begin : g_ofs_order_3
			$error("detection offset not above boost offset");
		end
	endgenerate

	// address decode, shared by the read and write paths
	function automatic logic bkdr_hit(input logic [`BKDR_ADDR_W-1:0] a);
		case (a)
			`BKDR_OFS_INPUT_DUTY,
			`BKDR_OFS_OUTPUT_DUTY,
			`BKDR_OFS_SINK_DAC,
			`BKDR_OFS_BOOST_CODE,
			`BKDR_OFS_DETECTION:   bkdr_hit = 1'b1;
			default:               bkdr_hit = 1'b0;
		endcase
	endfunction

	function automatic logic [`BKDR_IDX_W-1:0] bkdr_index(input logic [`BKDR_ADDR_W-1:0] a);
		case (a)
			`BKDR_OFS_INPUT_DUTY:  bkdr_index = `BKDR_IDX_INPUT_DUTY;
			`BKDR_OFS_OUTPUT_DUTY: bkdr_index = `BKDR_IDX_OUTPUT_DUTY;
			`BKDR_OFS_SINK_DAC:    bkdr_index = `BKDR_IDX_SINK_DAC;
			`BKDR_OFS_BOOST_CODE:  bkdr_index = `BKDR_IDX_BOOST_CODE;
			`BKDR_OFS_DETECTION:   bkdr_index = `BKDR_IDX_DETECTION;
			default:               bkdr_index = `BKDR_IDX_INPUT_DUTY;
		endcase
	endfunction

	// reserved bits forced low on the way out too, so a stray source bit never leaks
	function automatic logic [`BKDR_DATA_W-1:0] bkdr_live_mask(
		input logic [`BKDR_IDX_W-1:0] idx
	);
		case (idx)
			`BKDR_IDX_SINK_DAC: begin
				bkdr_live_mask = {{(`BKDR_DATA_W-`BKDR_DAC_W){1'b0}}, {`BKDR_DAC_W{1'b1}}};
			end
			`BKDR_IDX_BOOST_CODE: begin
				bkdr_live_mask = {{(`BKDR_DATA_W-`BKDR_BOOST_W){1'b0}},
					{`BKDR_BOOST_W{1'b1}}};
			end
			`BKDR_IDX_DETECTION: begin
				bkdr_live_mask = {{(`BKDR_DATA_W-`BKDR_DIM_MSB-1){1'b0}},
					{(`BKDR_DIM_MSB+1){1'b1}}};
			end
			default: begin
				bkdr_live_mask = {`BKDR_DATA_W{1'b1}};
			end
		endcase
	endfunction

	assign rd_index = bkdr_index(req.addr);
	assign rd_hit   = bkdr_hit(req.addr);

	// detection result word; reserved bits 15-9 stay zero
	always_comb begin
		det_word = `BKDR_RST_WORD;
		det_word[`BKDR_DIM_MSB:`BKDR_DIM_LSB] = src.detected_dimming_frequency;
		det_word[`BKDR_SW_MSB:`BKDR_SW_LSB]   = src.detected_switching_frequency;
		// codes 0-4 single strings, 5-7 grouped outputs
		det_word[`BKDR_GRP_MSB:`BKDR_GRP_LSB] = src.detected_string_grouping;
	end

	// zero-extended source words; padding keeps the reserved upper bits at zero
	always_comb begin
		src_word[`BKDR_IDX_INPUT_DUTY]  = src.input_duty;
		src_word[`BKDR_IDX_OUTPUT_DUTY] = src.applied_duty_code;
		src_word[`BKDR_IDX_SINK_DAC]    = {{(`BKDR_DATA_W-`BKDR_DAC_W){1'b0}},
			src.applied_sink_dac_code};
		// raw loop code; conversion to volts is left to software
		src_word[`BKDR_IDX_BOOST_CODE]  = {{(`BKDR_DATA_W-`BKDR_BOOST_W){1'b0}},
			src.adaptive_boost_code};
		src_word[`BKDR_IDX_DETECTION]   = det_word;
		src_load[`BKDR_IDX_INPUT_DUTY]  = src.input_duty_load;
		src_load[`BKDR_IDX_OUTPUT_DUTY] = src.duty_load;
		src_load[`BKDR_IDX_SINK_DAC]    = src.dac_load;
		src_load[`BKDR_IDX_BOOST_CODE]  = src.boost_load;
		// detection fields are taken together, once detection signals done
		src_load[`BKDR_IDX_DETECTION]   = src.detect_done;
	end

	// one holding register per readback word
	generate
		for (genvar i = 0; i < `BKDR_NUM_REGS; i++) begin : g_snap
			bkdr_snapshot #(
				.WIDTH (`BKDR_DATA_W)
			) u_snap (
				.core_clk (core_clk),
				.reset_n  (reset_n),
				.load     (src_load[i]),
				.value    (src_word[i]),
				.held     (held_word[i])
			);
		end
	endgenerate

	// a read answers one cycle later from the held word; nothing flows back to the sources
	always_comb begin
		state_nxt = state_r;
		state_nxt.rsp.ack      = 1'b0;
		state_nxt.rsp.addr_err = 1'b0;
		if (src.detect_done) begin
			state_nxt.detect_seen = 1'b1;
		end
		if (req.rd) begin
			state_nxt.rsp.ack      = 1'b1;
			state_nxt.rsp.addr_err = !rd_hit;
			if (rd_hit) begin
				state_nxt.rsp.rdata = held_word[rd_index] & bkdr_live_mask(rd_index);
			end else begin
				state_nxt.rsp.rdata = `BKDR_RST_WORD;
			end
		end else if (req.wr) begin
			// acknowledged so the serial side does not hang, data dropped
			state_nxt.rsp.ack      = 1'b1;
			state_nxt.rsp.addr_err = !rd_hit;
			state_nxt.rsp.rdata    = `BKDR_RST_WORD;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			state_r <= '{rsp: '{ack: 1'b0, addr_err: 1'b0, rdata: `BKDR_RST_WORD},
				detect_seen: 1'b0};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign rsp_r         = state_r.rsp;
	assign detect_seen_r = state_r.detect_seen;

endmodule

// ===== bkdr_readback_assertions.sv
`timescale 1ns/1ps
module bkdr_chk
	import bkdr_pkg::*;
(
	input wire logic         core_clk,
	input wire logic         reset_n,
	input wire bkdr_src_type src,
	input wire bkdr_req_type req,
	input wire bkdr_rsp_type rsp_r,
	input wire logic         detect_seen_r
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	ack_timing_a: assert property ((req.rd || req.wr) |=> rsp_r.ack)
		else $error("no ack one cycle after request");
	write_drop_a: assert property (req.wr && !req.rd |=>
		rsp_r.rdata == 16'h0000) else $error("write answer not zero");
	unmapped_addr_a: assert property ((req.rd || req.wr) &&
		!(req.addr inside {10'h2a6, 10'h2a8, 10'h2aa, 10'h2ac, 10'h2ae})
		|=> rsp_r.addr_err && rsp_r.rdata == 16'h0000) else $error("unmapped access not flagged");
	mapped_addr_a: assert property ((req.rd || req.wr) &&
		(req.addr inside {10'h2a6, 10'h2a8, 10'h2aa, 10'h2ac, 10'h2ae})
		|=> !rsp_r.addr_err) else $error("mapped access flagged");
	dac_top_a: assert property (req.rd && req.addr == 10'h2aa |=> rsp_r.rdata[15:12] == 4'h0)
		else $error("dac upper bits set");
	boost_top_a: assert property (req.rd && req.addr == 10'h2ac |=> rsp_r.rdata[15:11] == 5'h00)
		else $error("boost upper bits set");
	detect_top_a: assert property (req.rd && req.addr == 10'h2ae |=> rsp_r.rdata[15:9] == 7'h00)
		else $error("detection upper bits set");
	dac_value_a: assert property (src.dac_load ##1 (req.rd && req.addr == 10'h2aa &&
		!src.dac_load) |=> rsp_r.rdata[11:0] == $past(src.applied_sink_dac_code, 2))
		else $error("dac readback differs from load");
	rdata_hold_a: assert property (!rsp_r.ack && $past(reset_n) |-> $stable(rsp_r.rdata))
		else $error("rdata moved without ack");
	detect_seen_a: assert property (src.detect_done |=> detect_seen_r)
		else $error("detect seen flag not set");
	load_read_c: cover property (src.dac_load ##1 req.rd);
	write_c: cover property (req.wr ##1 rsp_r.ack);
	unmapped_c: cover property (rsp_r.addr_err);
endmodule

bind bkdr_readback bkdr_chk bkdr_chk_i (
	.core_clk      (core_clk),
	.reset_n       (reset_n),
	.src           (src),
	.req           (req),
	.rsp_r         (rsp_r),
	.detect_seen_r (detect_seen_r)
);

// ===== bkdr_readback_tb_top.sv
`timescale 1ns/1ps
module bkdr_readback_tb_top;
	import bkdr_pkg::*;
	logic         core_clk;
	logic         reset_n;
	bkdr_src_type src;
	bkdr_req_type req;
	bkdr_rsp_type rsp_r;
	logic         detect_seen_r;
	int           bad_count;
	int           total_checks;

	bkdr_readback bkdr_readback_i (
		.core_clk      (core_clk),
		.reset_n       (reset_n),
		.src           (src),
		.req           (req),
		.rsp_r         (rsp_r),
		.detect_seen_r (detect_seen_r)
	);

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic close_out;
		if (bad_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask

	// one request, answer looked at in the single ack cycle
	task automatic acc(input logic r, w, input logic [9:0] a, input logic [15:0] e, input logic er);
		@(negedge core_clk);
		req = '{rd: r, wr: w, addr: a, wdata: 16'hffff};
		@(negedge core_clk);
		req = '0;
		chk("ack", 16'h0001, {15'h0, rsp_r.ack});
		chk("addr_err", {15'h0, er}, {15'h0, rsp_r.addr_err});
		chk("rdata", e, rsp_r.rdata);
	endtask

	task automatic do_reset;
		@(negedge core_clk);
		reset_n = 1'b0;
		repeat (8) @(negedge core_clk);
		reset_n = 1'b1;
		chk("seen", 16'h0000, {15'h0, detect_seen_r});
		for (int i = 0; i < 5; i++)
			acc(1'b1, 1'b0, 10'h2a6 + 10'(2 * i), 16'h0000, 1'b0);
	endtask

	// all sources load together; upper bits of short fields must read zero
	task automatic t_load;
		@(negedge core_clk);
		src = '{16'hbeef, 1'b1, 16'h1234, 1'b1, 12'hfab, 1'b1, 11'h7cd, 1'b1,
			bkdr_dim_19k53hz, bkdr_sw_303khz, bkdr_grp_all_one, 1'b1};
		@(negedge core_clk);
		src.input_duty_load = 1'b0;
		src.duty_load = 1'b0;
		src.dac_load = 1'b0;
		src.boost_load = 1'b0;
		src.detect_done = 1'b0;
		acc(1'b1, 1'b0, 10'h2a6, 16'hbeef, 1'b0);
		acc(1'b1, 1'b0, 10'h2a8, 16'h1234, 1'b0);
		acc(1'b1, 1'b0, 10'h2aa, 16'h0fab, 1'b0);
		acc(1'b1, 1'b0, 10'h2ac, 16'h07cd, 1'b0);
		acc(1'b1, 1'b0, 10'h2ae, 16'h01c7, 1'b0);
		chk("seen", 16'h0001, {15'h0, detect_seen_r});
	endtask

	task automatic t_codes;
		for (int i = 0; i < 8; i++) begin
			@(negedge core_clk);
			src.detected_dimming_frequency = bkdr_dim_freq_type'(i[2:0]);
			src.detected_switching_frequency = bkdr_sw_freq_type'(3'h7 - i[2:0]);
			src.detected_string_grouping = bkdr_grouping_type'(i[2:0]);
			src.detect_done = 1'b1;
			@(negedge core_clk);
			src.detect_done = 1'b0;
			acc(1'b1, 1'b0, 10'h2ae, {7'h0, i[2:0], 3'h7 - i[2:0], i[2:0]}, 1'b0);
		end
	endtask

	// writes and stray offsets change nothing
	task automatic t_write;
		acc(1'b0, 1'b1, 10'h2aa, 16'h0000, 1'b0);
		acc(1'b1, 1'b1, 10'h2a8, 16'h1234, 1'b0);
		acc(1'b1, 1'b0, 10'h2a7, 16'h0000, 1'b1);
		acc(1'b1, 1'b0, 10'h000, 16'h0000, 1'b1);
		acc(1'b0, 1'b1, 10'h2b0, 16'h0000, 1'b1);
		acc(1'b1, 1'b0, 10'h2aa, 16'h0fab, 1'b0);
	endtask

	// a read in the load cycle sees the old word, never a mix
	task automatic t_coherent;
		@(negedge core_clk);
		src.applied_sink_dac_code = 12'h050;
		acc(1'b1, 1'b0, 10'h2aa, 16'h0fab, 1'b0);
		@(negedge core_clk);
		src.dac_load = 1'b1;
		req = '{rd: 1'b1, wr: 1'b0, addr: 10'h2aa, wdata: 16'h0000};
		@(negedge core_clk);
		src.dac_load = 1'b0;
		req = '0;
		chk("rdata", 16'h0fab, rsp_r.rdata);
		acc(1'b1, 1'b0, 10'h2aa, 16'h0050, 1'b0);
		// read taken at the edge right after the load sees the new word
		@(negedge core_clk);
		src.applied_sink_dac_code = 12'h3c3;
		src.dac_load = 1'b1;
		@(negedge core_clk);
		src.dac_load = 1'b0;
		req = '{rd: 1'b1, wr: 1'b0, addr: 10'h2aa, wdata: 16'h0000};
		@(negedge core_clk);
		req = '0;
		chk("ack", 16'h0001, {15'h0, rsp_r.ack});
		chk("rdata", 16'h03c3, rsp_r.rdata);
	endtask

	initial begin
		bad_count = 0;
		total_checks = 0;
		reset_n = 1'b0;
		src = '0;
		req = '0;
		repeat (8) @(negedge core_clk);
		reset_n = 1'b1;
		do_reset();
		t_load();
		t_codes();
		t_write();
		t_coherent();
		do_reset();
		close_out();
	end

	// whole run is about 110 cycles
	initial begin
		#40000;
		bad_count++;
		close_out();
	end
endmodule
